// *** tb/core_model.sv ***
// processor core stand-in: takes offered interrupts and issues returns
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic irq_req_i,
  input wire logic [7:0] irq_vector_i,
  input wire logic [1:0] irq_level_i,
  input wire logic ack_en_i,
  input wire logic [3:0] ack_wait_i,
  input wire logic ret_cmd_i,
  output logic irq_ack_o,
  output logic reti_o,
  output logic taken_o,
  output logic [7:0] taken_vector_o,
  output logic [1:0] taken_level_o
);
  logic [3:0] wait_cnt;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i) begin
    taken_o <= 1'b0;
    reti_o <= ret_cmd_i;
    if (rst_i) begin
      irq_ack_o <= 1'b0;
      reti_o <= 1'b0;
      wait_cnt <= 4'h0;
      taken_vector_o <= 8'h00;
      taken_level_o <= 2'h0;
    end else if (irq_ack_o) begin
      // vector may move to a better winner, so read it at the ack edge
      irq_ack_o <= 1'b0;
      taken_o <= irq_req_i;
      taken_vector_o <= irq_vector_i;
      taken_level_o <= irq_level_i;
      wait_cnt <= 4'h0;
    end else if (irq_req_i && ack_en_i) begin
      if (wait_cnt >= ack_wait_i) begin
        irq_ack_o <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else begin
      wait_cnt <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// *** tb/test_four_level_interrupt_priority.sv ***
// self-checking bench of the four-level interrupt priority block
`timescale 1ns/1ns
`default_nettype none
`define check(got, want) \
  begin \
    comparisons++; \
    if ((got) !== (want)) begin \
      errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, want); \
    end \
  end
module test_four_level_interrupt_priority;
  logic mclk_i, rst_i, wr_i, rd_i, irq_req_o, irq_ack, reti, alt;
  logic ack_en, ret_cmd, taken;
  logic [7:0] addr_i, wdata_i, rdata_o, irq_vector_o, taken_vector;
  logic [1:0] irq_level_o, taken_level;
  logic [3:0] ack_wait;
  logic [8:0] src;
  logic [7:0] vec8;
  int errors, comparisons;

  ////////////////////////////////////////////////////////////////////////////
  // src bits follow polling rank; alt moves shared sources to second flag
  irq_priority_top irq_priority_top_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext0_n_i(~src[0]), .ext1_n_i(~src[4]),
    .timer0_overflow_i(src[3]), .timer1_overflow_i(src[5]),
    .two_wire_unit_one_i(src[1]), .two_wire_unit_two_i(src[2]),
    .serial_receive_flag_i(src[6] & ~alt),
    .serial_transmit_flag_i(src[6] & alt),
    .timer2_overflow_flag_i(src[7] & ~alt),
    .timer2_external_flag_i(src[7] & alt),
    .counter_array_overflow_flag_i(src[8] & ~alt),
    .module_match_capture_flag_i({5{src[8] & alt}}),
    .irq_ack_i(irq_ack), .reti_i(reti), .irq_req_o(irq_req_o),
    .irq_vector_o(irq_vector_o), .irq_level_o(irq_level_o));

  // eight-source variant sees the same stimulus and the same acks
  irq_priority_top #(
    .TWO_BUS_UNITS(1'b0)
  ) irq_priority_top_8_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(),
    .ext0_n_i(~src[0]), .ext1_n_i(~src[4]),
    .timer0_overflow_i(src[3]), .timer1_overflow_i(src[5]),
    .two_wire_unit_one_i(src[1]), .two_wire_unit_two_i(src[2]),
    .serial_receive_flag_i(src[6] & ~alt),
    .serial_transmit_flag_i(src[6] & alt),
    .timer2_overflow_flag_i(src[7] & ~alt),
    .timer2_external_flag_i(src[7] & alt),
    .counter_array_overflow_flag_i(src[8] & ~alt),
    .module_match_capture_flag_i({5{src[8] & alt}}),
    .irq_ack_i(irq_ack), .reti_i(reti), .irq_req_o(),
    .irq_vector_o(vec8), .irq_level_o());

  core_model core_model_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .irq_req_i(irq_req_o),
    .irq_vector_i(irq_vector_o), .irq_level_i(irq_level_o),
    .ack_en_i(ack_en), .ack_wait_i(ack_wait), .ret_cmd_i(ret_cmd),
    .irq_ack_o(irq_ack), .reti_o(reti), .taken_o(taken),
    .taken_vector_o(taken_vector), .taken_level_o(taken_level));

  always #4 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] want);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    `check(rdata_o, want)
  endtask

  task automatic drive(input int idx, input logic v);
    @(posedge mclk_i);
    src[idx] <= v;
  endtask

  task automatic no_offer(input int n);
    repeat (n) begin
      @(negedge mclk_i);
      `check(irq_req_o, 1'b0)
    end
  endtask

  // w is the core's ack delay, so prompt and slow cores both appear
  task automatic serve(input logic [7:0] vec, input logic [1:0] lvl,
                       input logic [3:0] w);
    int n;
    n = 0;
    @(posedge mclk_i);
    ack_en <= 1'b1;
    ack_wait <= w;
    do begin
      @(negedge mclk_i);
      n++;
    end while (taken !== 1'b1 && n < 40);
    `check(taken, 1'b1)
    `check(taken_vector, vec)
    `check(taken_level, lvl)
    @(posedge mclk_i);
    ack_en <= 1'b0;
  endtask

  task automatic ret();
    @(posedge mclk_i);
    ret_cmd <= 1'b1;
    @(posedge mclk_i);
    ret_cmd <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask

  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    stop_test();
  end

  initial begin
    mclk_i = 1'b0;
    rst_i = 1'b1;
    {wr_i, rd_i, ack_en, ret_cmd, alt} = 5'h00;
    {addr_i, wdata_i} = 16'h0000;
    ack_wait = 4'h0;
    src = 9'h000;
    errors = 0;
    comparisons = 0;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd_check(irq_pkg::ADDR_ENABLE, irq_pkg::RST_REG);
    rd_check(irq_pkg::ADDR_PRIO_HIGH, irq_pkg::RST_REG);
    rd_check(irq_pkg::ADDR_PRIO_LOW, irq_pkg::RST_REG);
    wr(irq_pkg::ADDR_PRIO_LOW, 8'hff);
    rd_check(irq_pkg::ADDR_PRIO_LOW, irq_pkg::PRIO_MASK);
    wr(irq_pkg::ADDR_PRIO_HIGH, 8'hff);
    rd_check(irq_pkg::ADDR_PRIO_HIGH, irq_pkg::PRIO_MASK);
    wr(8'h55, 8'hff);
    rd_check(8'h55, 8'h00);
    wr(irq_pkg::ADDR_PRIO_LOW, 8'h00);
    wr(irq_pkg::ADDR_PRIO_HIGH, 8'h00);
    wr(irq_pkg::ADDR_TW_ENABLE, irq_pkg::TW_EN_MASK);
    // all level zero: one full polling pass per flag flavour
    for (int p = 0; p < 2; p++) begin
      wr(irq_pkg::ADDR_ENABLE, 8'h7f);
      @(posedge mclk_i);
      alt <= p[0];
      src <= 9'h1ff;
      @(posedge mclk_i);
      src <= 9'h1d7;
      no_offer(4);
      wr(irq_pkg::ADDR_ENABLE, 8'hff);
      rd_check(irq_pkg::ADDR_ENABLE, 8'hff);
      for (int i = 0; i < irq_pkg::NUM_SRC; i++) begin
        serve(irq_pkg::VECTOR[i], 2'h0, 4'(3 * (i % 2)));
        if (i == 0) rd_check(irq_pkg::ADDR_FLAGS, 8'h0f);
        // without unit two, timer 0 is next after unit one
        if (i == 2) begin
          @(negedge mclk_i);
          `check(vec8, 8'h0b)
        end
        if (i == 3) rd_check(irq_pkg::ADDR_FLAGS, 8'h0a);
        if (i == 5) rd_check(irq_pkg::ADDR_FLAGS, 8'h00);
        drive(i, 1'b0);
        no_offer(3);
        ret();
      end
    end
    // nesting: ext0 level 0, timer1 1, timer2 2, serial 3, ext1 1
    wr(irq_pkg::ADDR_PRIO_LOW, 8'h1c);
    wr(irq_pkg::ADDR_PRIO_HIGH, 8'h30);
    drive(0, 1'b1);
    serve(8'h03, 2'h0, 4'h0);
    drive(0, 1'b0);
    drive(5, 1'b1);
    drive(5, 1'b0);
    serve(8'h1b, 2'h1, 4'h0);
    drive(7, 1'b1);
    serve(8'h3b, 2'h2, 4'h2);
    drive(7, 1'b0);
    drive(6, 1'b1);
    serve(8'h23, 2'h3, 4'h0);
    drive(6, 1'b0);
    rd_check(irq_pkg::ADDR_IN_SERVICE, 8'h0f);
    drive(4, 1'b1);
    no_offer(4);
    ret();
    rd_check(irq_pkg::ADDR_IN_SERVICE, 8'h07);
    ret();
    no_offer(3);
    ret();
    serve(8'h13, 2'h1, 4'h1);
    drive(4, 1'b0);
    rd_check(irq_pkg::ADDR_IN_SERVICE, 8'h03);
    ret();
    ret();
    rd_check(irq_pkg::ADDR_IN_SERVICE, 8'h00);
    // edge mode: flag goes on vectoring although the pin stays low
    wr(irq_pkg::ADDR_EXT_MODE, 8'h01);
    drive(0, 1'b1);
    serve(8'h03, 2'h0, 4'h0);
    rd_check(irq_pkg::ADDR_FLAGS, 8'h00);
    ret();
    no_offer(4);
    drive(0, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire

// *** verilog/irq_if.sv ***
// priority and in-service signals shared between the interrupt modules
`timescale 1ns/1ns
`default_nettype none
interface irq_if;
  logic [irq_pkg::NUM_SRC-1:0] prio_low;
  logic [irq_pkg::NUM_SRC-1:0] prio_high;
  logic [irq_pkg::NUM_SRC-1:0][irq_pkg::LVL_W-1:0] level;
  logic take;
  logic [irq_pkg::LVL_W-1:0] take_level;
  logic ret;
  logic [irq_pkg::NUM_LVL-1:0] active;
  logic [irq_pkg::LVL_W-1:0] top_level;
  logic busy;
  modport mapper(input prio_low, prio_high, output level);
  modport tracker(input take, take_level, ret,
                  output active, top_level, busy);
  modport ctrl(output prio_low, prio_high, take, take_level, ret,
               input level, active, top_level, busy);
endinterface
`default_nettype wire

// *** verilog/irq_in_service.sv ***
// one in-service bit per level; return retires the highest
`timescale 1ns/1ns
`default_nettype none
module irq_in_service (
  input wire logic mclk_i,
  input wire logic rst_i,
  irq_if.tracker bus
);
  typedef struct packed {
    logic [irq_pkg::NUM_LVL-1:0] active;
  } svc_t;

  svc_t cur;
  svc_t next_cur;

  function automatic logic [irq_pkg::LVL_W-1:0] highest(
      input logic [irq_pkg::NUM_LVL-1:0] a);
    logic [irq_pkg::LVL_W-1:0] r;
    r = '0;
    for (int l = 0; l < irq_pkg::NUM_LVL; l++) begin
      if (a[l]) begin
        r = irq_pkg::LVL_W'(l);
      end
    end
    return r;
  endfunction

  always_comb begin
    next_cur = cur;
    // suspended lower levels stay marked until their own return
    if (bus.ret && (|cur.active)) begin
      next_cur.active[highest(cur.active)] = 1'b0; // [R10]
    end
    if (bus.take) begin
      next_cur.active[bus.take_level] = 1'b1; // [R9]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign bus.active = cur.active;
  assign bus.top_level = highest(cur.active);
  assign bus.busy = |cur.active;
endmodule
`default_nettype wire

// *** verilog/irq_level_map.sv ***
// two-bit priority level of every source from its high and low bits
`timescale 1ns/1ns
`default_nettype none
module irq_level_map (
  irq_if.mapper bus
);
  for (genvar k = 0; k < irq_pkg::NUM_SRC; k++) begin : g_map
    assign bus.level[k] = {bus.prio_high[k], bus.prio_low[k]}; // [R1]
  end
endmodule
`default_nettype wire

// *** verilog/irq_pkg.sv ***
// constants, register map and types of the four-level interrupt block
`default_nettype none
package irq_pkg;
  localparam int NUM_SRC = 9;
  localparam int NUM_LVL = 4;
  localparam int LVL_W = 2;
  localparam int SRC_W = 4;

  // polling order of the nine-source variant; index is polling rank
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_TW1 = 4'h1;
  localparam logic [3:0] SRC_TW2 = 4'h2;
  localparam logic [3:0] SRC_T0 = 4'h3;
  localparam logic [3:0] SRC_EXT1 = 4'h4;
  localparam logic [3:0] SRC_T1 = 4'h5;
  localparam logic [3:0] SRC_SERIAL = 4'h6;
  localparam logic [3:0] SRC_T2 = 4'h7;
  localparam logic [3:0] SRC_ARRAY = 4'h8;

  localparam logic [7:0] VECTOR [NUM_SRC] = '{
    8'h03, 8'h2b, 8'h43, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h3b, 8'h33};
  // bit of each source inside its enable / priority register
  localparam logic [2:0] ENABLE_BIT [NUM_SRC] = '{
    3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
  // sources whose bits live in the two-wire registers
  localparam logic [NUM_SRC-1:0] IN_TW = 9'h006;
  localparam logic [2:0] TW_HIGH_SHIFT = 3'h4;
  localparam int BIT_GLOBAL = 7;

  localparam logic [7:0] ADDR_ENABLE = 8'ha8;
  localparam logic [7:0] ADDR_PRIO_HIGH = 8'hb7;
  localparam logic [7:0] ADDR_PRIO_LOW = 8'hb8;
  localparam logic [7:0] ADDR_TW_ENABLE = 8'he8;
  localparam logic [7:0] ADDR_TW_PRIO = 8'he9;
  localparam logic [7:0] ADDR_FLAGS = 8'hea;
  localparam logic [7:0] ADDR_IN_SERVICE = 8'heb;
  localparam logic [7:0] ADDR_EXT_MODE = 8'hec;

  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] PRIO_MASK = 8'h7f;
  localparam logic [7:0] TW_EN_MASK = 8'h03;
  localparam logic [7:0] TW_PRIO_MASK = 8'h33;
  localparam logic [7:0] EXT_MODE_MASK = 8'h03;
  localparam logic [1:0] RST_EXT_PREV = 2'h3;

  // flag register: bits 0/1 external, 2/3 timer 0/1
  localparam int FLG_TIMER_BASE = 2;
  localparam int NUM_FLAGS = 4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OFFER = 2'b01,
    ST_HOLD = 2'b11
  } offer_state_t;
endpackage
`default_nettype wire

// *** verilog/irq_priority_top.sv ***
// four-level nested interrupt priority, enable and vector logic
//
// Overview of operation
// R1: level is high bit then low bit
// R2: nine sources polled in fixed polling-rank order
// R3: eight-source variant skips second two-wire unit
// R4: level-mode external flag follows pin, no clear
// R5: transition-mode external flag cleared when vectored
// R6: global enable gates all individual enables
// R7: serve only above the level in service
// R8: equal or lower level waits for return
// R9: higher level preempts immediately, four deep
// R10: return resumes suspended lower level
// R11: timer 0/1 flags cleared on vectoring
// R12: enable and priority bits written by software
`timescale 1ns/1ns
`default_nettype none
module irq_priority_top #(
  parameter bit TWO_BUS_UNITS = 1'b1,
  parameter int NUM_MODULES = 5
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic ext0_n_i,
  input wire logic ext1_n_i,
  input wire logic timer0_overflow_i,
  input wire logic timer1_overflow_i,
  input wire logic two_wire_unit_one_i,
  input wire logic two_wire_unit_two_i,
  input wire logic serial_receive_flag_i,
  input wire logic serial_transmit_flag_i,
  input wire logic timer2_overflow_flag_i,
  input wire logic timer2_external_flag_i,
  input wire logic counter_array_overflow_flag_i,
  input wire logic [NUM_MODULES-1:0] module_match_capture_flag_i,
  input wire logic irq_ack_i,
  input wire logic reti_i,
  output logic irq_req_o,
  output logic [7:0] irq_vector_o,
  output logic [1:0] irq_level_o
);
  localparam int N = irq_pkg::NUM_SRC;

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] prio_high;
    logic [7:0] prio_low;
    logic [7:0] tw_enable;
    logic [7:0] tw_prio;
    logic [7:0] ext_mode;
    logic [irq_pkg::NUM_FLAGS-1:0] flags;
    logic [1:0] ext_prev;
    irq_pkg::offer_state_t state;
    logic [7:0] vector;
    logic [1:0] level;
    logic [irq_pkg::SRC_W-1:0] source;
    logic [7:0] rdata;
  } ctl_t;

  ctl_t cur;
  ctl_t next_cur;

  irq_if bus ();

  irq_level_map u_map (
    .bus(bus.mapper)
  );

  irq_in_service u_svc (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .bus(bus.tracker)
  );

  ////////////////////////////////////////////////////////////////////
  // request, enable and priority per source

  logic [N-1:0] pend;
  logic [N-1:0] en;
  logic [N-1:0] elig;
  logic [irq_pkg::SRC_W:0] win;
  logic take;

  assign pend[irq_pkg::SRC_EXT0] = cur.flags[0];
  assign pend[irq_pkg::SRC_TW1] = two_wire_unit_one_i;
  // eight-source variant: second unit never requests
  assign pend[irq_pkg::SRC_TW2] = two_wire_unit_two_i & TWO_BUS_UNITS; // [R3]
  assign pend[irq_pkg::SRC_T0] = cur.flags[irq_pkg::FLG_TIMER_BASE];
  assign pend[irq_pkg::SRC_EXT1] = cur.flags[1];
  assign pend[irq_pkg::SRC_T1] = cur.flags[irq_pkg::FLG_TIMER_BASE + 1];
  assign pend[irq_pkg::SRC_SERIAL] = serial_receive_flag_i |
                                     serial_transmit_flag_i;
  assign pend[irq_pkg::SRC_T2] = timer2_overflow_flag_i |
                                 timer2_external_flag_i;
  assign pend[irq_pkg::SRC_ARRAY] = counter_array_overflow_flag_i |
                                    (|module_match_capture_flag_i);

  for (genvar k = 0; k < N; k++) begin : g_src
    localparam logic [2:0] B = irq_pkg::ENABLE_BIT[k];
    localparam logic [2:0] BH = 3'(B + irq_pkg::TW_HIGH_SHIFT);
    if (irq_pkg::IN_TW[k]) begin : g_tw
      assign en[k] = cur.tw_enable[B]; // [R12]
      assign bus.prio_low[k] = cur.tw_prio[B]; // [R12]
      assign bus.prio_high[k] = cur.tw_prio[BH];
    end else begin : g_sfr
      assign en[k] = cur.enable[B]; // [R12]
      assign bus.prio_low[k] = cur.prio_low[B]; // [R12]
      assign bus.prio_high[k] = cur.prio_high[B];
    end
    // only a level above the one in service may be vectored
    assign elig[k] = pend[k] & en[k] & cur.enable[irq_pkg::BIT_GLOBAL] &
                     (~bus.busy | (bus.level[k] > bus.top_level)); // [R6]
  end

  // highest level first, then lowest polling rank
  function automatic logic [irq_pkg::SRC_W:0] pick(
      input logic [N-1:0] e,
      input logic [N-1:0][1:0] lv);
    logic [irq_pkg::SRC_W:0] r;
    r = '0;
    for (int l = irq_pkg::NUM_LVL - 1; l >= 0; l--) begin
      for (int k = 0; k < N; k++) begin
        if (!r[irq_pkg::SRC_W] && e[k] && lv[k] == 2'(l)) begin
          r = {1'b1, irq_pkg::SRC_W'(k)}; // [R2]
        end
      end
    end
    return r;
  endfunction

  assign win = pick(elig, bus.level); // [R7] [R8]
  assign take = (cur.state == irq_pkg::ST_OFFER) && irq_ack_i;
  assign bus.take = take; // [R9]
  assign bus.take_level = cur.level;
  assign bus.ret = reti_i; // [R10]

  ////////////////////////////////////////////////////////////////////
  // next state

  logic [1:0] ext_n;
  logic [1:0] tov;
  logic [irq_pkg::NUM_FLAGS-1:0] w1c;

  assign ext_n = {ext1_n_i, ext0_n_i};
  assign tov = {timer1_overflow_i, timer0_overflow_i};
  assign w1c = (wr_i && addr_i == irq_pkg::ADDR_FLAGS) ?
               wdata_i[irq_pkg::NUM_FLAGS-1:0] : '0;

  always_comb begin
    logic [3:0] ext_src [2];
    logic [3:0] tim_src [2];
    ext_src = '{irq_pkg::SRC_EXT0, irq_pkg::SRC_EXT1};
    tim_src = '{irq_pkg::SRC_T0, irq_pkg::SRC_T1};
    next_cur = cur;
    next_cur.ext_prev = ext_n;
    next_cur.rdata = irq_pkg::RST_REG;

    if (wr_i) begin
      case (addr_i)
        irq_pkg::ADDR_ENABLE: next_cur.enable = wdata_i; // [R12]
        irq_pkg::ADDR_PRIO_HIGH: begin
          next_cur.prio_high = wdata_i & irq_pkg::PRIO_MASK; // [R12]
        end
        irq_pkg::ADDR_PRIO_LOW: begin
          next_cur.prio_low = wdata_i & irq_pkg::PRIO_MASK; // [R12]
        end
        irq_pkg::ADDR_TW_ENABLE: begin
          next_cur.tw_enable = wdata_i & irq_pkg::TW_EN_MASK;
        end
        irq_pkg::ADDR_TW_PRIO: begin
          next_cur.tw_prio = wdata_i & irq_pkg::TW_PRIO_MASK;
        end
        irq_pkg::ADDR_EXT_MODE: begin
          next_cur.ext_mode = wdata_i & irq_pkg::EXT_MODE_MASK;
        end
        default: ;
      endcase
    end

    if (rd_i) begin
      case (addr_i)
        irq_pkg::ADDR_ENABLE: next_cur.rdata = cur.enable;
        irq_pkg::ADDR_PRIO_HIGH: next_cur.rdata = cur.prio_high;
        irq_pkg::ADDR_PRIO_LOW: next_cur.rdata = cur.prio_low;
        irq_pkg::ADDR_TW_ENABLE: next_cur.rdata = cur.tw_enable;
        irq_pkg::ADDR_TW_PRIO: next_cur.rdata = cur.tw_prio;
        irq_pkg::ADDR_EXT_MODE: next_cur.rdata = cur.ext_mode;
        irq_pkg::ADDR_FLAGS: next_cur.rdata = 8'(cur.flags);
        irq_pkg::ADDR_IN_SERVICE: next_cur.rdata = 8'(bus.active);
        default: next_cur.rdata = irq_pkg::RST_REG;
      endcase
    end

    // clear first, so an event in the same cycle wins
    for (int i = 0; i < 2; i++) begin
      if (cur.ext_mode[i]) begin
        if ((take && cur.source == ext_src[i]) || w1c[i]) begin
          next_cur.flags[i] = 1'b0; // [R5]
        end
        if (cur.ext_prev[i] && !ext_n[i]) begin
          next_cur.flags[i] = 1'b1;
        end
      end else begin
        // low input requests for as long as it stays low
        next_cur.flags[i] = ~ext_n[i]; // [R4]
      end
      if ((take && cur.source == tim_src[i]) ||
          w1c[irq_pkg::FLG_TIMER_BASE + i]) begin
        next_cur.flags[irq_pkg::FLG_TIMER_BASE + i] = 1'b0; // [R11]
      end
      if (tov[i]) begin
        next_cur.flags[irq_pkg::FLG_TIMER_BASE + i] = 1'b1;
      end
    end

    // hold one cycle after ack so cleared flags are not re-offered
    case (cur.state)
      irq_pkg::ST_IDLE: begin
        if (win[irq_pkg::SRC_W]) begin
          next_cur.state = irq_pkg::ST_OFFER; // [R9]
        end
      end
      irq_pkg::ST_OFFER: begin
        if (irq_ack_i) begin
          next_cur.state = irq_pkg::ST_HOLD;
        end else if (!win[irq_pkg::SRC_W]) begin
          next_cur.state = irq_pkg::ST_IDLE;
        end
      end
      irq_pkg::ST_HOLD: next_cur.state = irq_pkg::ST_IDLE;
      default: next_cur.state = irq_pkg::ST_IDLE;
    endcase

    if (next_cur.state == irq_pkg::ST_OFFER && !take) begin
      next_cur.source = win[irq_pkg::SRC_W-1:0];
      next_cur.vector = irq_pkg::VECTOR[win[irq_pkg::SRC_W-1:0]]; // [R2]
      next_cur.level = bus.level[win[irq_pkg::SRC_W-1:0]];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cur <= '{
        enable: irq_pkg::RST_REG,
        prio_high: irq_pkg::RST_REG,
        prio_low: irq_pkg::RST_REG,
        tw_enable: irq_pkg::RST_REG,
        tw_prio: irq_pkg::RST_REG,
        ext_mode: irq_pkg::RST_REG,
        flags: '0,
        ext_prev: irq_pkg::RST_EXT_PREV,
        state: irq_pkg::ST_IDLE,
        vector: irq_pkg::RST_REG,
        level: '0,
        source: '0,
        rdata: irq_pkg::RST_REG
      };
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata_o = cur.rdata;
  assign irq_req_o = (cur.state == irq_pkg::ST_OFFER);
  assign irq_vector_o = cur.vector;
  assign irq_level_o = cur.level;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_level_code;
    bus.level[irq_pkg::SRC_EXT0] ==
      {cur.prio_high[0], cur.prio_low[0]};
  endproperty
  a_level_code: assert property (p_level_code) else $error("lvl"); // [R1]

  property p_vector_table;
    irq_req_o && cur.source == irq_pkg::SRC_TW2 |-> irq_vector_o == 8'h43;
  endproperty
  a_vector_table: assert property (p_vector_table) else $error("vec"); // [R2]

  property p_no_unit_two;
    !TWO_BUS_UNITS && irq_req_o |-> cur.source != irq_pkg::SRC_TW2;
  endproperty
  a_no_unit_two: assert property (p_no_unit_two) else $error("tw2"); // [R3]

  // level mode: flag is the inverted pin of the cycle before
  property p_level_mode;
    !cur.ext_mode[0] |=> cur.flags[0] == !$past(ext0_n_i);
  endproperty
  a_level_mode: assert property (p_level_mode) else $error("lvm"); // [R4]

  property p_edge_clear;
    take && cur.source == irq_pkg::SRC_EXT0 && cur.ext_mode[0] &&
      !(cur.ext_prev[0] && !ext0_n_i) |=> !cur.flags[0];
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("edg"); // [R5]

  property p_global_off;
    !cur.enable[irq_pkg::BIT_GLOBAL] |=> !irq_req_o;
  endproperty
  a_global_off: assert property (p_global_off) else $error("glb"); // [R6]

  property p_above_service;
    irq_req_o && bus.busy |-> irq_level_o > bus.top_level;
  endproperty
  a_above_service: assert property (p_above_service) else $error("svc"); // [R7]

  property p_wait_return;
    bus.busy && bus.top_level == 2'h3 && !reti_i |=> !irq_req_o;
  endproperty
  a_wait_return: assert property (p_wait_return) else $error("wt"); // [R8]

  property p_preempt;
    cur.state == irq_pkg::ST_IDLE && win[irq_pkg::SRC_W] |=>
      irq_req_o ##0 irq_level_o == $past(bus.level[win[3:0]]);
  endproperty
  a_preempt: assert property (p_preempt) else $error("pre"); // [R9]

  property p_resume;
    reti_i && !take && $countones(bus.active) >= 2 |=>
      bus.active != '0 ##0 bus.active == ($past(bus.active) &
        ~(4'h1 << $past(bus.top_level)));
  endproperty
  a_resume: assert property (p_resume) else $error("res"); // [R10]

  property p_timer_clear;
    take && cur.source == irq_pkg::SRC_T0 && !timer0_overflow_i |=>
      !cur.flags[irq_pkg::FLG_TIMER_BASE];
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("tmr"); // [R11]

  property p_enable_write;
    wr_i && addr_i == irq_pkg::ADDR_ENABLE |=>
      cur.enable == $past(wdata_i);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("wr"); // [R12]

  c_preempt: cover property (irq_req_o && bus.busy && take);
  c_nested: cover property ($countones(bus.active) >= 3);
  c_unit_two: cover property (take && cur.source == irq_pkg::SRC_TW2);
endmodule
`default_nettype wire
